// ### include/spi_buf_pkg.sv
// shared constants for the link-to-user port buffer
package spi_buf_pkg;
	localparam int PATH_W_WIDE = 128;
	localparam int PATH_W_MED = 64;
	localparam int PATH_W_NARROW = 32;
	localparam int ADDR_W = 8;
	localparam int MAX_PORTS_SHARED = 256;
	localparam int MAX_PORTS_INDIV = 16;
	localparam int BUF_BYTES_MIN = 512;
	localparam int BUF_BYTES_MAX = 32768;
	localparam int STATUS_W = 2;
	localparam int NARROW_MAX_MBPS = 250;
	localparam int RATE_DIV_WIDE = 8;
	localparam int RATE_DIV_MED = 4;
	localparam int RATE_DIV_NARROW = 2;
	localparam int DDR_DIV = 2;
	localparam logic [1:0] STAT_SATISFIED = 2'h2;
	localparam logic [1:0] STAT_STARVING = 2'h0;
	localparam logic [1:0] STAT_HUNGRY = 2'h1;
	typedef enum logic [0:0] {
		MODE_SHARED = 1'b0,
		MODE_INDIV = 1'b1
	} buf_mode_t;
endpackage

// ### rtl/spi_rx_port_buffer.sv
// receive-side port buffer: link words into shared or per-port fifos
`timescale 1ns/1ps
module spi_rx_port_buffer #(
	parameter int PATH_W = spi_buf_pkg::PATH_W_MED,
	parameter int USER_W = spi_buf_pkg::PATH_W_MED,
	parameter bit INDIV = 1'b1,
	parameter int NUM_PORTS = 4,
	parameter int BUF_BYTES = spi_buf_pkg::BUF_BYTES_MIN,
	parameter bit MULTI_CLK = 1'b0,
	parameter bit EDGE_PROG = 1'b1,
	parameter bit EDGE_FALL = 1'b0,
	localparam int NFIFO = INDIV ? NUM_PORTS : 1,
	localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1,
	localparam int DEPTH = BUF_BYTES * 8 / PATH_W,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic link_clk,
	input wire logic [PATH_W-1:0] link_data,
	input wire logic [spi_buf_pkg::ADDR_W-1:0] link_port,
	input wire logic link_valid,
	input wire logic rx_status_edge_select,
	output logic [spi_buf_pkg::STATUS_W-1:0] status_rise,
	output logic [spi_buf_pkg::STATUS_W-1:0] status_fall,
	output logic status_launch_fall,
	output logic link_overflow,
	output logic multi_phy,
	input wire logic [NFIFO-1:0] user_clk,
	input wire logic [NFIFO-1:0] user_ready,
	output logic [NFIFO-1:0] user_valid,
	output logic [NFIFO*USER_W-1:0] user_data,
	output logic [NFIFO*spi_buf_pkg::ADDR_W-1:0] user_port
);
	localparam int EW = PATH_W + spi_buf_pkg::ADDR_W;
	localparam bit DOUBLE = (USER_W == 2 * PATH_W);
	// width combinations fixed at build time
	initial begin
		// three path widths; word clock set by link rate
		if (PATH_W != spi_buf_pkg::PATH_W_WIDE && PATH_W != spi_buf_pkg::PATH_W_MED
			&& PATH_W != spi_buf_pkg::PATH_W_NARROW)
			$error("unsupported path width");
		if (NUM_PORTS < 1 || NUM_PORTS > spi_buf_pkg::MAX_PORTS_SHARED)
			$error("bad port count");
		if (!(USER_W == PATH_W || (DOUBLE && PATH_W != spi_buf_pkg::PATH_W_WIDE)))
			$error("unsupported user width");
		if (INDIV && NUM_PORTS > spi_buf_pkg::MAX_PORTS_INDIV)
			$error("too many individual ports");
		if (BUF_BYTES < spi_buf_pkg::BUF_BYTES_MIN || BUF_BYTES > spi_buf_pkg::BUF_BYTES_MAX
			|| (BUF_BYTES & (BUF_BYTES - 1)) != 0)
			$error("bad buffer size");
	end

	assign multi_phy = (NUM_PORTS > 1);

	// edge strap caught at reset release
	logic edge_sync1_q, edge_sync2_q, edge_q, edge_d;
	logic edge_sync1_d, edge_sync2_d;
	always_comb begin
		edge_sync1_d = rx_status_edge_select;
		edge_sync2_d = edge_sync1_q;
		// held after reset: a strap glitch mid-run cannot move the edge
		edge_d = edge_q;
		if (reset)
			edge_d = EDGE_PROG ? edge_sync2_q : EDGE_FALL;
	end
	always_ff @(posedge clk) begin
		edge_sync1_q <= edge_sync1_d;
		edge_sync2_q <= edge_sync2_d;
		edge_q <= edge_d;
	end
	assign status_launch_fall = edge_q;

	// no scheduler here: a receiver only reports status
	logic [NFIFO-1:0] full_s, hungry_s;
	// automatic status per fifo fill, no user input
	logic [spi_buf_pkg::STATUS_W-1:0] stat_d, stat_q;
	always_comb begin
		stat_d = spi_buf_pkg::STAT_STARVING;
		if (|full_s)
			stat_d = spi_buf_pkg::STAT_SATISFIED;
		else if (|hungry_s)
			stat_d = spi_buf_pkg::STAT_HUNGRY;
		// satisfied through reset so the peer holds its traffic
		if (reset)
			stat_d = spi_buf_pkg::STAT_SATISFIED;
	end
	always_ff @(posedge clk) begin
		stat_q <= stat_d;
	end

	// both edges offered; the pad picks by launch edge
	// unused copy parks at satisfied: a wrong pad choice stalls rather than floods
	logic [spi_buf_pkg::STATUS_W-1:0] rise_d, rise_q, fall_d, fall_q;
	always_comb begin
		rise_d = spi_buf_pkg::STAT_SATISFIED;
		fall_d = spi_buf_pkg::STAT_SATISFIED;
		if (edge_d)
			fall_d = stat_d;
		else
			rise_d = stat_d;
	end
	always_ff @(posedge clk) begin
		rise_q <= rise_d;
		fall_q <= fall_d;
	end
	assign status_rise = rise_q;
	assign status_fall = fall_q;

	// link-side reset, two flops into link domain
	logic lrst1_q, lrst1_d, lrst2_q, lrst2_d;
	always_comb begin
		lrst1_d = reset;
		lrst2_d = lrst1_q;
	end
	always_ff @(posedge link_clk) begin
		lrst1_q <= lrst1_d;
		lrst2_q <= lrst2_d;
	end

	// a drop flips a toggle; the core side turns each flip into one pulse
	logic [NFIFO-1:0] ovf_l;
	logic ovf_tog_d, ovf_tog_q;
	always_comb begin
		ovf_tog_d = ovf_tog_q ^ (|ovf_l);
		if (lrst2_q)
			ovf_tog_d = 1'b0;
	end
	always_ff @(posedge link_clk) begin
		ovf_tog_q <= ovf_tog_d;
	end

	// the second and third flops feed the edge compare
	logic ot1_q, ot1_d, ot2_q, ot2_d, ot3_q, ot3_d, ovf_d, ovf_q;
	always_comb begin
		ot1_d = ovf_tog_q;
		ot2_d = ot1_q;
		ot3_d = ot2_q;
		ovf_d = ot2_q ^ ot3_q;
		if (reset)
			ovf_d = 1'b0;
	end
	always_ff @(posedge clk) begin
		ot1_q <= ot1_d;
		ot2_q <= ot2_d;
		ot3_q <= ot3_d;
		ovf_q <= ovf_d;
	end
	assign link_overflow = ovf_q;

	function automatic logic [AW:0] b2g(input logic [AW:0] b);
		b2g = b ^ (b >> 1);
	endfunction
	function automatic logic [AW:0] g2b(input logic [AW:0] g);
		logic [AW:0] b;
		b = '0;
		for (int i = AW; i >= 0; i--)
			b[i] = g[i] ^ ((i == AW) ? 1'b0 : b[i+1]);
		g2b = b;
	endfunction

	// one fifo per port when INDIV, else one shared fifo; identical shape
	genvar f;
	generate
		for (f = 0; f < NFIFO; f++) begin : g_fifo
			// read clock is user clock when MULTI_CLK; else core clock
			wire rclk = MULTI_CLK ? user_clk[f] : clk;
			// entry holds port address with data
			logic [EW-1:0] mem_q [DEPTH];
			logic [EW-1:0] mem_d [DEPTH];
			logic [AW:0] wp_q, wp_d, wg_q, wg_d;
			logic [AW:0] rp_q, rp_d, rg_q, rg_d;
			logic [AW:0] rg1_q, rg1_d, rg2_q, rg2_d;
			logic [AW:0] wg1_q, wg1_d, wg2_q, wg2_d;
			logic sel, wr, rd, full, empty;

			assign sel = INDIV ? (link_port[PW-1:0] == PW'(f)) : 1'b1;
			// a stale read pointer can only make the ring look fuller
			assign full = (wg_q == {~rg2_q[AW:AW-1], rg2_q[AW-2:0]});
			// written from the link side only, no transmit path
			assign wr = link_valid && sel && !full;
			assign ovf_l[f] = link_valid && sel && full;

			// strict arrival order in one ring
			always_comb begin
				wp_d = wp_q + (AW+1)'(wr);
				wg_d = b2g(wp_d);
				if (lrst2_q) begin
					wp_d = '0;
					wg_d = '0;
				end
			end
			always_ff @(posedge link_clk) begin
				wp_q <= wp_d;
				wg_q <= wg_d;
			end

			// read pointer into the link domain, gray so one bit moves
			always_comb begin
				rg1_d = rg_q;
				rg2_d = rg1_q;
			end
			always_ff @(posedge link_clk) begin
				rg1_q <= rg1_d;
				rg2_q <= rg2_d;
			end

			// one register per entry, loaded at the write pointer
			for (genvar e = 0; e < DEPTH; e++) begin : g_entry
				always_comb begin
					mem_d[e] = mem_q[e];
					if (wr && wp_q[AW-1:0] == AW'(e))
						mem_d[e] = {link_port, link_data};
				end
				always_ff @(posedge link_clk) begin
					mem_q[e] <= mem_d[e];
				end
			end

			// read domain: reset and write pointer through two flops each
			logic rrst1_q, rrst1_d, rrst2_q, rrst2_d;
			always_comb begin
				rrst1_d = reset;
				rrst2_d = rrst1_q;
				wg1_d = wg_q;
				wg2_d = wg1_q;
			end
			always_ff @(posedge rclk) begin
				rrst1_q <= rrst1_d;
				rrst2_q <= rrst2_d;
				wg1_q <= wg1_d;
				wg2_q <= wg2_d;
			end
			assign empty = (rg_q == wg2_q);

			// fill level seen from the read side
			logic [AW:0] fill;
			logic half_full, quarter_full;
			assign fill = g2b(wg2_q) - rp_q;
			assign half_full = fill[AW] || fill[AW-1];
			assign quarter_full = fill[AW-1:AW-2] == 2'h1;

			// fill flags are levels of the read clock; two flops bring them to clk
			logic [1:0] lvl1_q, lvl1_d, lvl2_q, lvl2_d;
			always_comb begin
				lvl1_d = {half_full, quarter_full};
				lvl2_d = lvl1_q;
			end
			always_ff @(posedge clk) begin
				lvl1_q <= lvl1_d;
				lvl2_q <= lvl2_d;
			end
			assign full_s[f] = lvl2_q[1];
			assign hungry_s[f] = lvl2_q[0];

			// read pointer advances on every word taken from the ring
			always_comb begin
				rp_d = rp_q + (AW+1)'(rd);
				rg_d = b2g(rp_d);
				if (rrst2_q) begin
					rp_d = '0;
					rg_d = '0;
				end
			end
			always_ff @(posedge rclk) begin
				rp_q <= rp_d;
				rg_q <= rg_d;
			end

			// pack two path words, first low
			logic half_q, half_d, ov_q, ov_d;
			logic [USER_W-1:0] od_q, od_d;
			logic [spi_buf_pkg::ADDR_W-1:0] op_q, op_d;
			logic [EW-1:0] head;
			assign head = mem_q[rp_q[AW-1:0]];
			always_comb begin
				rd = 1'b0;
				half_d = half_q;
				ov_d = ov_q && !user_ready[f];
				od_d = od_q;
				op_d = op_q;
				if (!empty && (!ov_q || user_ready[f])) begin
					rd = 1'b1;
					op_d = head[EW-1:PATH_W];
					if (DOUBLE) begin
						od_d[(half_q ? PATH_W : 0) +: PATH_W] = head[PATH_W-1:0];
						half_d = !half_q;
						ov_d = half_q;
					end else begin
						od_d[PATH_W-1:0] = head[PATH_W-1:0];
						ov_d = 1'b1;
					end
				end
				// output stage cleared with the read-side reset
				if (rrst2_q) begin
					half_d = 1'b0;
					ov_d = 1'b0;
					od_d = '0;
					op_d = '0;
				end
			end
			always_ff @(posedge rclk) begin
				half_q <= half_d;
				ov_q <= ov_d;
				od_q <= od_d;
				op_q <= op_d;
			end

			// every fifo drives the same user width
			assign user_valid[f] = ov_q;
			assign user_data[f*USER_W +: USER_W] = od_q;
			assign user_port[f*spi_buf_pkg::ADDR_W +: spi_buf_pkg::ADDR_W] = op_q;
		end
	endgenerate
endmodule

// ### tb/spi_rx_port_buffer_monitor.sv
// checker bound to the receive port buffer
`timescale 1ns/1ps
module spi_rx_port_buffer_monitor #(
	parameter int USER_W = 64,
	parameter bit INDIV = 1'b1,
	parameter int NUM_PORTS = 4,
	localparam int NF = INDIV ? NUM_PORTS : 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic link_valid,
	input wire logic [1:0] status_rise,
	input wire logic [1:0] status_fall,
	input wire logic status_launch_fall,
	input wire logic link_overflow,
	input wire logic multi_phy,
	input wire logic [NF-1:0] user_ready,
	input wire logic [NF-1:0] user_valid,
	input wire logic [NF*USER_W-1:0] user_data
);
	logic [1:0] live;
	assign live = status_launch_fall ? status_fall : status_rise;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence stall0;
		user_valid[0] && !user_ready[0];
	endsequence
	AST_PHY: assert property (multi_phy == (NUM_PORTS > 1)) else $error("phy mode");
	AST_RST: assert property ($fell(reset) |-> live == 2'h2
		&& user_valid == '0) else $error("reset state");
	AST_EDGE: assert property (!$past(reset) |-> $stable(status_launch_fall))
		else $error("edge moved");
	AST_IDLE: assert property ((status_launch_fall ? status_rise : status_fall) == 2'h2)
		else $error("idle copy");
	AST_CODE: assert property (live != 2'h3) else $error("bad code");
	AST_HOLD: assert property (stall0 |=> user_valid[0]) else $error("valid dropped");
	AST_DATA: assert property (stall0 |=> $stable(user_data[USER_W-1:0]))
		else $error("data moved");
	AST_ARRIVE: assert property ($rose(link_valid) |-> ##[1:16] user_valid != '0)
		else $error("word lost");
	AST_FULL: assert property (link_overflow |-> ##[0:8] live == 2'h2)
		else $error("full not satisfied");
endmodule
bind spi_rx_port_buffer spi_rx_port_buffer_monitor #(.USER_W(USER_W), .INDIV(INDIV),
	.NUM_PORTS(NUM_PORTS)) mon_i (.clk, .reset, .link_valid, .status_rise, .status_fall,
	.status_launch_fall, .link_overflow, .multi_phy, .user_ready, .user_valid, .user_data);

// ### tb/link_peer.sv
// link-side peer sending addressed words
`timescale 1ns/1ps
module link_peer (
	input wire logic link_clk,
	output logic [63:0] link_data,
	output logic [7:0] link_port,
	output logic link_valid
);
	initial begin
		link_data = 64'h0;
		link_port = 8'h00;
		link_valid = 1'b0;
	end
	// launched after an edge, held to the next
	task automatic send(input logic [7:0] p, input logic [63:0] d);
		@(posedge link_clk);
		link_port <= p;
		link_data <= d;
		link_valid <= 1'b1;
	endtask
	// idle lines never repeat the last word
	task automatic idle();
		@(posedge link_clk);
		link_valid <= 1'b0;
		link_data <= ~link_data;
		link_port <= ~link_port;
	endtask
endmodule

// ### tb/test_spi_rx_port_buffer.sv
// testbench for the receive port buffer
`timescale 1ns/1ps
module test_spi_rx_port_buffer;
	logic clk, reset, link_clk, sel, link_valid, launch_fall, link_overflow, multi_phy, seen;
	logic [63:0] link_data;
	logic [7:0] link_port;
	logic [1:0] status_rise, status_fall;
	logic [3:0] user_ready, user_valid;
	logic [255:0] user_data;
	logic [31:0] user_port;
	int failures, check_count, cycles;
	// four ports, inside the ten-port advice; falling launch opposite peer sampling
	spi_rx_port_buffer spi_rx_port_buffer_i (.clk, .reset, .link_clk, .link_data, .link_port,
		.link_valid, .rx_status_edge_select(sel), .status_rise, .status_fall,
		.status_launch_fall(launch_fall), .link_overflow, .multi_phy, .user_clk({4{clk}}),
		.user_ready, .user_valid, .user_data, .user_port);
	link_peer link_peer_i (.link_clk, .link_data, .link_port, .link_valid);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// link clock kept unrelated in phase
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (link_overflow === 1'b1) seen <= 1'b1;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// reset outlasts four link edges too
	task automatic do_reset(input logic s);
		sel = s;
		reset = 1'b1;
		repeat (6) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic take(input int p, input logic [63:0] d);
		int n = 0;
		while (user_valid[p] !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check(user_data[p*64 +: 64], d);
		check(user_port[p*8 +: 8], 64'(p));
		user_ready[p] = 1'b1;
		@(negedge clk);
		user_ready[p] = 1'b0;
	endtask
	task automatic close_out();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		user_ready = 4'h0;
		seen = 1'b0;
		sel = 1'b1;
		@(negedge clk);
		do_reset(1'b1);
		check(launch_fall, 1'b1);
		check(multi_phy, 1'b1);
		// every port to its own fifo, then a second word behind
		for (int p = 0; p < 4; p++) link_peer_i.send(8'(p), 64'hA0 + 64'(p));
		link_peer_i.send(8'h02, 64'hB2);
		link_peer_i.idle();
		for (int p = 0; p < 4; p++) take(p, 64'hA0 + 64'(p));
		take(2, 64'hB2);
		// ring of 64 plus output register hold 65 words; the 66th drops
		for (int i = 0; i <= 65; i++) link_peer_i.send(8'h01, 64'(i));
		link_peer_i.idle();
		repeat (8) @(negedge clk);
		check(seen, 1'b1);
		check(status_fall, 2'h2);
		check(status_rise, 2'h2);
		for (int i = 0; i < 65; i++) take(1, 64'(i));
		repeat (8) @(negedge clk);
		check(user_valid, 4'h0);
		check(status_fall, 2'h0);
		do_reset(1'b0);
		check(launch_fall, 1'b0);
		check(status_fall, 2'h2);
		check(status_rise, 2'h0);
		close_out();
	end
endmodule
